// *** core/cam_track_pkg.sv ***
// Shared constants and types for the cam track evaluator and its consumer
package cam_track_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CAMS = 30;
  localparam int NUM_TRACKS = 4;
  localparam int NUM_RANGES = 15;
  localparam int POS_W = 32;
  localparam int ASSIGN_W = 9;
  localparam int FEN_W = 16;
  localparam int RANGE_W = 4;

  // ==========================================================================
  // Function enable word fields
  localparam int FEN_SYNC_BIT = 7;
  localparam int FEN_CAM_LO = 8;
  localparam int FEN_CAM_HI = 15;

  // ==========================================================================
  // Range code values
  localparam logic [RANGE_W-1:0] RANGE_BEYOND = 4'hF;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h0;

  // ==========================================================================
  // Track assignment encoding: hundreds pick the track, rest is the range
  localparam logic [ASSIGN_W-1:0] ASSIGN_STEP = 9'h064;
  localparam logic [ASSIGN_W-1:0] ASSIGN_MAX_RANGE = 9'h00E;

  // Channel indices
  localparam int CH_KERNEL = 0;
  localparam int CH_DRIVE = 1;

  // Decoded track assignment of one cam
  typedef struct packed {
    logic ok;
    logic [1:0] trk;
    logic [RANGE_W-1:0] rng;
  } asg_t;

  // Decode an assignment value; ok stays low for anything out of range
  function automatic asg_t asg_decode(input logic [ASSIGN_W-1:0] v);
    asg_t r;
    logic [ASSIGN_W-1:0] base;
    r = '0;
    for (int t = 0; t < NUM_TRACKS; t++) begin
      base = ASSIGN_W'(ASSIGN_STEP * ASSIGN_W'(t + 1));
      if (v >= base && v <= base + ASSIGN_MAX_RANGE) begin
        r.ok = 1'b1;
        r.trk = 2'(t);
        r.rng = RANGE_W'(v - base);
      end
    end
    return r;
  endfunction : asg_decode

endpackage : cam_track_pkg

// *** core/cam_track_if.sv ***
// Link between the cam track evaluator and the consuming safe logic
`timescale 1ns/1ns
interface cam_track_if;
  logic [cam_track_pkg::NUM_TRACKS-1:0] track_active;
  logic [cam_track_pkg::NUM_TRACKS-1:0][cam_track_pkg::RANGE_W-1:0] range_code;
  logic [cam_track_pkg::NUM_TRACKS-1:0][cam_track_pkg::NUM_RANGES-1:0]
    range_bits;

  modport dev_mp (
    output track_active,
    output range_code,
    output range_bits
  );

  modport logic_mp (
    input track_active,
    input range_code,
    input range_bits
  );
endinterface : cam_track_if

// *** core/cam_channel_eval.sv ***
// One monitoring channel: cam hysteresis, track activity and range code
`timescale 1ns/1ns
module cam_channel_eval #(
  parameter int POS_W = cam_track_pkg::POS_W,
  parameter int NUM_CAMS = cam_track_pkg::NUM_CAMS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Evaluation enable and axis position
  input wire logic i_run,
  input wire logic signed [POS_W-1:0] i_pos,
  // Cam configuration
  input wire logic [NUM_CAMS-1:0] i_cam_en,
  input wire logic [NUM_CAMS-1:0][POS_W-1:0] i_upper,
  input wire logic [NUM_CAMS-1:0][POS_W-1:0] i_lower,
  input wire logic [POS_W-1:0] i_cam_tol,
  input wire cam_track_pkg::asg_t [NUM_CAMS-1:0] i_asg,
  // Per track results
  output logic [cam_track_pkg::NUM_TRACKS-1:0] o_track_act,
  output logic [cam_track_pkg::NUM_TRACKS-1:0][cam_track_pkg::RANGE_W-1:0]
    o_range
);

  localparam int XW = POS_W + 2;
  localparam int NT = cam_track_pkg::NUM_TRACKS;

  logic [NUM_CAMS-1:0] on_q;
  logic [NUM_CAMS-1:0] above_q;
  logic [NUM_CAMS-1:0] live;
  logic [NUM_CAMS-1:0] is_next;
  logic signed [XW-1:0] pos_x;
  logic signed [XW-1:0] tol_x;
  logic [NT-1:0] act_d;
  logic [NT-1:0][cam_track_pkg::RANGE_W-1:0] rng_d;
  logic [NT-1:0] found;

  assign pos_x = XW'(i_pos);
  assign tol_x = XW'(i_cam_tol);

  // ==========================================================================
  // Per cam hysteresis and passed state
  for (genvar c = 0; c < NUM_CAMS; c++) begin : g_cam
    logic signed [XW-1:0] lo_x;
    logic signed [XW-1:0] hi_x;
    logic [NUM_CAMS-1:0] beats;

    assign lo_x = XW'(signed'(i_lower[c]));
    assign hi_x = XW'(signed'(i_upper[c]));
    assign live[c] = i_cam_en[c] & i_asg[c].ok;

    // Band is widened while on and narrowed while off, so no flicker
    always_ff @(posedge i_clk) begin
      if (!i_resetn || !i_run) begin
        on_q[c] <= 1'b0;
      end else if (on_q[c]) begin
        on_q[c] <= pos_x >= lo_x - tol_x && pos_x <= hi_x + tol_x; // [R17] [R23]
      end else begin
        on_q[c] <= live[c] && pos_x >= lo_x + tol_x
                   && pos_x <= hi_x - tol_x; // [R17] [R23]
      end
    end

    // Passed marks the falling edge upward; preset from position when idle.
    // It clears where the cam turns on again from above, so an active
    // track never shows the code of the next cam or the beyond code.
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        above_q[c] <= 1'b0;
      end else if (!i_run) begin
        above_q[c] <= pos_x > hi_x;
      end else if (above_q[c]) begin
        above_q[c] <= pos_x > hi_x - tol_x; // [R12] [R23]
      end else begin
        above_q[c] <= pos_x > hi_x + tol_x; // [R12] [R17]
      end
    end

    // A lower unpassed cam on the same track takes precedence
    for (genvar d = 0; d < NUM_CAMS; d++) begin : g_other
      if (d == c) begin : g_self
        assign beats[d] = 1'b0;
      end else begin : g_cmp
        assign beats[d] = live[d] && !above_q[d]
          && i_asg[d].trk == i_asg[c].trk
          && (signed'(i_lower[d]) < signed'(i_lower[c])
              || (i_lower[d] == i_lower[c] && d < c));
      end
    end
    assign is_next[c] = live[c] & ~above_q[c] & ~|beats; // [R11] [R12]
  end

  // ==========================================================================
  // Track OR and range selection
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      act_d[t] = 1'b0;
      rng_d[t] = cam_track_pkg::RANGE_BEYOND; // [R11]
      found[t] = 1'b0;
      for (int c = 0; c < NUM_CAMS; c++) begin
        if (i_asg[c].trk == 2'(t)) begin
          if (on_q[c] && live[c]) begin
            act_d[t] = 1'b1; // [R10]
          end
          if (is_next[c] && !found[t]) begin
            rng_d[t] = i_asg[c].rng; // [R11] [R12]
            found[t] = 1'b1;
          end
        end
      end
    end
  end

  // Outputs fall to zero while the channel may not evaluate
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_run) begin
      o_track_act <= '0; // [R15]
      o_range <= {NT{cam_track_pkg::RANGE_RESET}};
    end else begin
      o_track_act <= act_d;
      o_range <= rng_d;
    end
  end

endmodule : cam_channel_eval

// *** core/cam_track_evaluator.sv ***
// Two channel safe cam track evaluator: checks, sync and output registers
`timescale 1ns/1ns
// Rules for this block, its consumer and the configurer
// R01: Cams enabled need function word bits 8-15 clear
// R02: Cams enabled forbid cam synchronization enable bit
// R03: Cams enabled forbid nonzero modulo range
// R04: Cam length at least tolerance sum
// R05: Gap between track neighbours at least tolerance sum
// R06: No two cams share track and range
// R07: Every enabled cam needs valid track assignment
// R08: Failed check raises kernel alarm and drive fault
// R09: Configurer keeps rotary range within 2048 turns
// R10: Track active is OR of its cams
// R11: Below first cam its range; beyond last 15
// R12: Range advances at falling edge moving up
// R13: Channels cross-compare configuration; mismatch is fault (code leaves modulo range and both tolerances out of the compare)
// R14: Four tracks: active, range code, fifteen bits
// R15: Faults drive outputs to safe zero
// R16: Consumer qualifies range code with track active
// R17: Rising positions switch at position plus tolerance
// R18: Synced track active is AND of channels
// R19: Differing channels adopt other channel's range code
// R20: Fifteen range bits per track from range
// R21: Assignment hundreds pick track, rest range
// R22: Thirty cams over four tracks, fifteen each
// R23: Falling positions switch at position minus tolerance
module cam_track_evaluator #(
  parameter int POS_W = cam_track_pkg::POS_W,
  parameter int NUM_CAMS = cam_track_pkg::NUM_CAMS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Per channel state, index 0 kernel channel, index 1 drive channel
  input wire logic [1:0] i_referenced,
  input wire logic [1:0][POS_W-1:0] i_pos,
  // Per channel configuration
  input wire logic [1:0][NUM_CAMS-1:0] i_cam_enable_mask,
  input wire logic [1:0][cam_track_pkg::FEN_W-1:0] i_function_enable_word,
  input wire logic [1:0][POS_W-1:0] i_modulo_range_setting,
  input wire logic [1:0][NUM_CAMS-1:0][POS_W-1:0] i_cam_upper_position,
  input wire logic [1:0][NUM_CAMS-1:0][POS_W-1:0] i_cam_lower_position,
  input wire logic [1:0][POS_W-1:0] i_cam_tolerance,
  input wire logic [1:0][POS_W-1:0] i_crosswise_position_tolerance,
  input wire logic [1:0][NUM_CAMS-1:0][cam_track_pkg::ASSIGN_W-1:0]
    i_cam_track_assignment,
  // Link to the consuming safe logic
  cam_track_if.dev_mp cam_out,
  // Alarms
  output logic o_param_alarm,
  output logic o_cam_pos_fault,
  output logic o_cross_fault
);

  localparam int XW = POS_W + 2;
  localparam int NT = cam_track_pkg::NUM_TRACKS;
  localparam int RW = cam_track_pkg::RANGE_W;
  localparam int NR = cam_track_pkg::NUM_RANGES;
  localparam int KC = cam_track_pkg::CH_KERNEL;
  localparam int DC = cam_track_pkg::CH_DRIVE;

  // ==========================================================================
  // Elaboration check
  if (NUM_CAMS < 1 || NUM_CAMS > cam_track_pkg::NUM_CAMS || POS_W < 8)
  begin : g_bad_param
    $error("cam_track_evaluator: unsupported NUM_CAMS or POS_W");
  end

  logic [1:0] bad_cfg;
  logic [1:0] alarm_q;
  logic cross_q;
  logic mismatch;
  logic [1:0] run;
  logic [1:0][NT-1:0] act;
  logic [1:0][NT-1:0][RW-1:0] rng;
  logic [NT-1:0] sync_act;
  logic [NT-1:0][RW-1:0] sync_rng;

  // ==========================================================================
  // Boot-time style configuration check, evaluated per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    cam_track_pkg::asg_t [NUM_CAMS-1:0] asg;
    logic [NUM_CAMS-1:0] bad_cam;
    logic signed [XW-1:0] tol_sum;
    logic any_en;
    logic bad_glob;

    assign tol_sum = XW'(i_cam_tolerance[ch])
                   + XW'(i_crosswise_position_tolerance[ch]);
    assign any_en = |i_cam_enable_mask[ch];

    // Function word and modulo setting only matter once cams are enabled
    assign bad_glob = any_en && (
      |i_function_enable_word[ch][cam_track_pkg::FEN_CAM_HI:
                                  cam_track_pkg::FEN_CAM_LO] // [R01]
      || i_function_enable_word[ch][cam_track_pkg::FEN_SYNC_BIT] // [R02]
      || i_modulo_range_setting[ch] != '0); // [R03]

    for (genvar i = 0; i < NUM_CAMS; i++) begin : g_cam
      logic signed [XW-1:0] up_i;
      logic signed [XW-1:0] lo_i;
      logic [NUM_CAMS-1:0] bad_pair;

      assign asg[i] = cam_track_pkg::asg_decode(
        i_cam_track_assignment[ch][i]); // [R21]
      assign up_i = XW'(signed'(i_cam_upper_position[ch][i]));
      assign lo_i = XW'(signed'(i_cam_lower_position[ch][i]));

      // Pairs are checked from the lower cam so each gap is seen once
      for (genvar j = 0; j < NUM_CAMS; j++) begin : g_pair
        if (j == i) begin : g_self
          assign bad_pair[j] = 1'b0;
        end else begin : g_cmp
          logic signed [XW-1:0] lo_j;
          assign lo_j = XW'(signed'(i_cam_lower_position[ch][j]));
          assign bad_pair[j] = i_cam_enable_mask[ch][i]
            && i_cam_enable_mask[ch][j] && asg[i].ok && asg[j].ok
            && asg[i].trk == asg[j].trk
            && (asg[i].rng == asg[j].rng // [R06] [R22]
                || (lo_j >= lo_i && lo_j - up_i < tol_sum)); // [R05]
        end
      end

      assign bad_cam[i] = i_cam_enable_mask[ch][i] && (
        up_i - lo_i < tol_sum // [R04]
        || !asg[i].ok // [R07]
        || |bad_pair);
    end

    assign bad_cfg[ch] = bad_glob | (|bad_cam);

    // Sticky until reset: a bad configuration stays alarmed
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        alarm_q[ch] <= 1'b0;
      end else if (bad_cfg[ch]) begin
        alarm_q[ch] <= 1'b1; // [R08]
      end
    end

    // Channel runs only when referenced and free of faults
    assign run[ch] = i_referenced[ch] & ~|alarm_q & ~cross_q; // [R15]

    cam_channel_eval #(
      .POS_W(POS_W),
      .NUM_CAMS(NUM_CAMS)
    ) u_eval (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_run(run[ch]),
      .i_pos(signed'(i_pos[ch])),
      .i_cam_en(i_cam_enable_mask[ch]),
      .i_upper(i_cam_upper_position[ch]),
      .i_lower(i_cam_lower_position[ch]),
      .i_cam_tol(i_cam_tolerance[ch]),
      .i_asg(asg),
      .o_track_act(act[ch]),
      .o_range(rng[ch])
    );
  end

  // ==========================================================================
  // Crosswise comparison of the two channels' configuration
  assign mismatch =
    i_cam_enable_mask[KC] != i_cam_enable_mask[DC]
    || i_function_enable_word[KC] != i_function_enable_word[DC]
    || i_cam_upper_position[KC] != i_cam_upper_position[DC]
    || i_cam_lower_position[KC] != i_cam_lower_position[DC]
    || i_cam_track_assignment[KC] != i_cam_track_assignment[DC]; // [R13]

  // A mismatch latches so a transient difference still forces safe state
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cross_q <= 1'b0;
    end else if (mismatch) begin
      cross_q <= 1'b1; // [R13]
    end
  end

  // Alarm outputs, one per channel's own check plus the crosswise fault
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_param_alarm <= 1'b0;
      o_cam_pos_fault <= 1'b0;
      o_cross_fault <= 1'b0;
    end else begin
      o_param_alarm <= alarm_q[KC]; // [R08]
      o_cam_pos_fault <= alarm_q[DC]; // [R08]
      o_cross_fault <= cross_q;
    end
  end

  // ==========================================================================
  // Channel synchronization
  // The kernel channel's range code is presented; it adopts the drive range only
  // when it alone sees the track active with a different code.
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      sync_act[t] = act[KC][t] & act[DC][t]; // [R18]
      if (rng[KC][t] != rng[DC][t] && act[KC][t] != act[DC][t]
          && act[KC][t]) begin
        sync_rng[t] = rng[DC][t]; // [R19]
      end else begin
        sync_rng[t] = rng[KC][t];
      end
    end
  end

  // ==========================================================================
  // Output registers toward the safe logic
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cam_out.track_active <= '0;
      cam_out.range_code <= {NT{cam_track_pkg::RANGE_RESET}};
    end else begin
      cam_out.track_active <= sync_act; // [R14] [R18]
      cam_out.range_code <= sync_rng; // [R14]
    end
  end

  // Range bits: one per range, set while on the cam of that range
  for (genvar t = 0; t < NT; t++) begin : g_trk
    for (genvar r = 0; r < NR; r++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          cam_out.range_bits[t][r] <= 1'b0;
        end else begin
          cam_out.range_bits[t][r] <= sync_act[t]
            && sync_rng[t] == RW'(r); // [R20] [R14]
        end
      end
    end
  end

endmodule : cam_track_evaluator

// *** core/cam_track_consumer.sv ***
// Consuming safe logic end: qualifies cam signals into enables
`timescale 1ns/1ns
module cam_track_consumer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link from the evaluator
  cam_track_if.logic_mp cam_in,
  // Range wanted per track before an action is allowed
  input wire logic [cam_track_pkg::NUM_TRACKS-1:0][cam_track_pkg::RANGE_W-1:0]
    i_wanted_range,
  // Enables, high only in the wanted zone
  output logic [cam_track_pkg::NUM_TRACKS-1:0] o_zone_enable,
  output logic [cam_track_pkg::NUM_TRACKS-1:0] o_range_bit_enable
);

  localparam int NT = cam_track_pkg::NUM_TRACKS;
  localparam int NR = cam_track_pkg::NUM_RANGES;

  // ==========================================================================
  // Enables: zero is safe, so only a confirmed one lets an action through
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_zone_enable <= '0;
      o_range_bit_enable <= '0;
    end else begin
      for (int t = 0; t < NT; t++) begin
        // Range code alone is never trusted
        o_zone_enable[t] <= cam_in.track_active[t]
          && cam_in.range_code[t] == i_wanted_range[t]; // [R16] [R15]
        o_range_bit_enable[t] <= i_wanted_range[t] < 4'(NR)
          && cam_in.range_bits[t][i_wanted_range[t]]; // [R15]
      end
    end
  end

endmodule : cam_track_consumer

// *** tb/cam_track_asserts.sv ***
// Checker on the link between cam track evaluator and consumer
`timescale 1ns/1ns
module cam_track_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link signals
  input wire logic [cam_track_pkg::NUM_TRACKS-1:0] track_active,
  input wire logic [cam_track_pkg::NUM_TRACKS-1:0][cam_track_pkg::RANGE_W-1:0]
    range_code,
  input wire logic [cam_track_pkg::NUM_TRACKS-1:0]
    [cam_track_pkg::NUM_RANGES-1:0] range_bits
);
  // ==========================================================================
  // Reset behaviour of the whole link
  a_reset_zero: assert property (
    @(posedge i_clk) !i_resetn |=> track_active == '0 && range_code == '0
      && range_bits == '0)
    else $error("link not cleared by reset");
  // Pipeline is three deep, so nothing may light up sooner
  a_release_quiet: assert property (
    @(posedge i_clk) $rose(i_resetn) |-> (track_active == '0) [*3])
    else $error("track active too soon after reset");

  // ==========================================================================
  // Per track relations between active, code and bits
  for (genvar t = 0; t < cam_track_pkg::NUM_TRACKS; t++) begin : g_trk
    a_bits_code: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      range_bits[t] == ((track_active[t] && range_code[t] != 4'hF) ?
        15'h0001 << range_code[t] : 15'h0000))
      else $error("range bits disagree with code");
    a_bits_onehot: assert property (
      @(posedge i_clk) disable iff (!i_resetn) $onehot0(range_bits[t]))
      else $error("more than one range bit set");
    a_bits_need_active: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      |range_bits[t] |-> track_active[t])
      else $error("range bit set on idle track");
    a_active_code: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      track_active[t] |-> range_code[t] != 4'hF)
      else $error("active track shows beyond code");
    a_rise_bit: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(track_active[t]) |-> range_code[t] != 4'hF
        && range_bits[t][range_code[t]])
      else $error("no range bit when track goes active");
    a_fall_clears: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      $fell(track_active[t]) |-> range_bits[t] == '0
        && $past(range_bits[t]) != '0)
      else $error("range bits wrong when track leaves cam");
  end
endmodule : cam_track_asserts

// *** tb/test_cam_track_evaluator.sv ***
// Testbench joining the evaluator and consumer across the cam track link
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  errors++; $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
  end end
module test_cam_track_evaluator;
  localparam int PW = cam_track_pkg::POS_W;
  localparam int NC = cam_track_pkg::NUM_CAMS;
  // ==========================================================================
  // Stimulus and observed signals
  logic i_clk, i_resetn;
  logic [1:0] referenced;
  logic [1:0][PW-1:0] pos, modr, ctol, ptol;
  logic [1:0][NC-1:0] cam_en;
  logic [1:0][15:0] fen;
  logic [1:0][NC-1:0][PW-1:0] upper, lower;
  logic [1:0][NC-1:0][8:0] asg;
  logic [3:0][3:0] wanted;
  logic [3:0] zone, rbe;
  logic param_alarm, pos_fault, cross_fault;
  int errors = 0;
  int n_tests = 0;

  // ==========================================================================
  // Design ends and checker
  cam_track_if link ();
  cam_track_evaluator cam_track_evaluator_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_referenced(referenced), .i_pos(pos),
    .i_cam_enable_mask(cam_en), .i_function_enable_word(fen),
    .i_modulo_range_setting(modr), .i_cam_upper_position(upper),
    .i_cam_lower_position(lower), .i_cam_tolerance(ctol),
    .i_crosswise_position_tolerance(ptol), .i_cam_track_assignment(asg),
    .cam_out(link), .o_param_alarm(param_alarm),
    .o_cam_pos_fault(pos_fault), .o_cross_fault(cross_fault));
  cam_track_consumer cam_track_consumer_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .cam_in(link), .i_wanted_range(wanted),
    .o_zone_enable(zone), .o_range_bit_enable(rbe));
  cam_track_asserts cam_track_asserts_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .track_active(link.track_active),
    .range_code(link.range_code), .range_bits(link.range_bits));

  // Clock at 250 MHz
  initial begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Helpers; inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic cam(input int i, input logic [PW-1:0] lo, up,
                     input logic [8:0] a);
    for (int ch = 0; ch < 2; ch++) begin
      lower[ch][i] = lo;
      upper[ch][i] = up;
      asg[ch][i] = a;
    end
  endtask : cam
  // Five cams on track 2 plus the last cam index alone on track 4
  task automatic set_good();
    fen = '0;
    modr = '0;
    upper = '0;
    lower = '0;
    asg = '0;
    cam_en = {2{30'h200000A7}};
    ctol = {2{32'h00000005}};
    ptol = {2{32'h00000002}};
    cam(0, 32'h1C7, 32'h1E0, 9'h0C9);
    cam(1, 32'h050, 32'h078, 9'h0CB);
    cam(2, 32'h12C, 32'h140, 9'h0CA);
    cam(5, 32'h0AA, 32'h0C8, 9'h0CC);
    cam(7, 32'h15E, 32'h17C, 9'h0CD);
    cam(29, 32'h3E8, 32'h44C, 9'h190); // Far inside the safe span
  endtask : set_good
  // Config is static, so every scenario starts from a fresh reset
  task automatic do_reset();
    i_resetn = 1'h0;
    step(16);
    i_resetn = 1'h1;
  endtask : do_reset
  // Three edges through the evaluator, one more through the consumer, one spare
  task automatic go(input logic [PW-1:0] k, d);
    pos[0] = k;
    pos[1] = d;
    step(5);
  endtask : go
  task automatic chk_trk(input logic a, input logic [3:0] c);
    `CHK(link.track_active[1], a)
    `CHK(link.range_code[1], c)
    `CHK(link.range_bits[1], (a && c != 4'hF) ? 15'h0001 << c : 15'h0000)
  endtask : chk_trk

  // ==========================================================================
  // Scenarios
  task automatic s_walk();
    set_good();
    wanted = {4'h0, 4'hF, 4'h3, 4'hF};
    do_reset();
    go(32'h0, 32'h0);
    chk_trk(1'h0, 4'h3);
    `CHK(param_alarm, 1'h0)
    go(32'h54, 32'h54);
    chk_trk(1'h0, 4'h3);
    go(32'h55, 32'h55);
    chk_trk(1'h1, 4'h3);
    `CHK(zone[1], 1'h1)
    `CHK(rbe, 4'h2)
    go(32'h7D, 32'h7D);
    chk_trk(1'h1, 4'h3);
    go(32'h7E, 32'h7E);
    chk_trk(1'h0, 4'h4);
    `CHK(zone[1], 1'h0)
    go(32'h258, 32'h258);
    chk_trk(1'h0, 4'hF);
    go(32'h1D6, 32'h1D6);
    chk_trk(1'h1, 4'h1);
    go(32'h1C3, 32'h1C3);
    chk_trk(1'h1, 4'h1);
    go(32'h1C1, 32'h1C1);
    chk_trk(1'h0, 4'h1);
    go(32'h1C7, 32'h1C7);
    chk_trk(1'h0, 4'h1);
    go(32'h41A, 32'h41A);
    `CHK(link.track_active, 4'h8)
    `CHK(link.range_code[3], 4'h0)
    `CHK(zone, 4'h8)
  endtask : s_walk

  // One bad setting at a time, same in both channels
  task automatic s_cfg_checks();
    for (int k = 1; k <= 7; k++) begin
      set_good();
      for (int ch = 0; ch < 2; ch++) begin
        case (k)
          1: fen[ch] = 16'h0100;
          2: fen[ch] = 16'h0080;
          3: modr[ch] = 32'h00000168;
          4: upper[ch][2] = 32'h131;
          5: lower[ch][7] = 32'h143;
          6: asg[ch][5] = 9'h0CA;
          default: asg[ch][7] = 9'h000;
        endcase
      end
      pos = {2{32'h64}};
      do_reset();
      step(5);
      `CHK(param_alarm, 1'h1)
      `CHK(pos_fault, 1'h1)
      `CHK(cross_fault, 1'h0)
      `CHK(link.track_active, 4'h0)
      `CHK(link.range_bits, '0)
    end
  endtask : s_cfg_checks

  task automatic s_cross();
    set_good();
    upper[1][0] = 32'h1EA;
    pos = {2{32'h64}};
    do_reset();
    step(5);
    `CHK(cross_fault, 1'h1)
    `CHK(param_alarm, 1'h0)
    `CHK(link.track_active, 4'h0)
  endtask : s_cross

  // Channels disagree: kernel on the cam, drive past it, then swapped
  task automatic s_sync();
    set_good();
    do_reset();
    go(32'h64, 32'h8C);
    `CHK(link.track_active[1], 1'h0)
    `CHK(link.range_code[1], 4'h4)
    `CHK(link.range_bits[1], 15'h0000)
    go(32'h8C, 32'h64);
    `CHK(link.range_code[1], 4'h4)
  endtask : s_sync

  task automatic s_unref();
    set_good();
    do_reset();
    go(32'h64, 32'h64);
    chk_trk(1'h1, 4'h3);
    referenced = 2'h1;
    step(5);
    chk_trk(1'h0, 4'h0);
    `CHK(zone[1], 1'h0)
    referenced = 2'h3;
  endtask : s_unref

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    i_resetn = 1'h0;
    referenced = 2'h3;
    pos = '0;
    wanted = '0;
    set_good();
    s_walk();
    s_cfg_checks();
    s_cross();
    s_sync();
    s_unref();
    end_of_test();
  end

  // Tests need about a microsecond; a hundred is a clear hang
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : test_cam_track_evaluator
